/* File: hub_cfg_defs.svh */
// Purpose: Offsets, bit positions and reset values of the hub identity and configuration bytes.
// Assumes: Byte-wide register access, offsets are byte addresses.
// Notes: Definitions only.
`ifndef HUB_CFG_DEFS_SVH
`define HUB_CFG_DEFS_SVH

// Byte offsets
`define OFS_SIGNATURE 8'h00
`define OFS_VENDOR_ID_HIGH 8'h02
`define OFS_PRODUCT_ID_LOW 8'h03
`define OFS_PRODUCT_ID_HIGH 8'h04
`define OFS_DEVICE_CONFIG 8'h05

// Signature a valid EEPROM image starts with
`define EEPROM_SIGNATURE 8'h55

// Reset values; identity bytes are arbitrary neutral values
`define RST_VENDOR_ID_HIGH 8'h12
`define RST_PRODUCT_ID_LOW 8'h34
`define RST_PRODUCT_ID_HIGH 8'h56

// Device configuration bit positions
`define BIT_RSVD_HIGH 7
`define BIT_CUSTOM_SERIAL 6
`define BIT_LP_DISABLE 5
`define BIT_PORT_IND 4
`define BIT_GANGED 3
`define BIT_PWR_MGMT 2
`define BIT_TIMEOUT_OVR 1
`define BIT_RSVD_LOW 0

// Writable mask of the configuration byte (bits 6..1)
`define CFG_WRITE_MASK 8'h7E
// Bit toggled in the legacy-speed product code
`define PID_LEGACY_TOGGLE 8'h02
// Timeout value forced by the override
`define TIMEOUT_FORCED 8'hFF

`endif

/* File: hub_cfg_pkg.sv */
// Purpose: Types shared by the hub configuration register bank.
// Assumes: Nothing beyond the defs header.
// Notes: Types only.
package hub_cfg_pkg;

   // Source that currently owns register writes
   typedef enum logic [1:0] {
      MODE_DEFAULT,
      MODE_EEPROM,
      MODE_SMBUS
   } cfg_mode_e;

   // Loader progress for an EEPROM image
   typedef enum logic [1:0] {
      LOAD_IDLE,
      LOAD_CHECK,
      LOAD_COPY,
      LOAD_DONE
   } load_state_e;

   typedef logic [7:0] cfg_byte_t;

endpackage

/* File: hub_timeout_override.sv */
// Purpose: Apply the link idle timeout override to a downstream timeout value.
// Assumes: Combinational, one per downstream port.
// Notes: A zero timeout always stays zero.
`include "hub_cfg_defs.svh"

module hub_timeout_override (
   // Control
   input wire logic override_en,
   // Timeout
   input wire hub_cfg_pkg::cfg_byte_t timeout_in,
   output hub_cfg_pkg::cfg_byte_t timeout_out
);

   // Nonzero values are pushed to the ceiling, zero means disabled and is kept
   wire logic is_nonzero;
   assign is_nonzero = |timeout_in;
   assign timeout_out = (override_en && is_nonzero) ? `TIMEOUT_FORCED : timeout_in;

endmodule

/* File: hub_link_pm_gate.sv */
// Purpose: Gate U1/U2 entry requests under the low-power disable bit.
// Assumes: Force accept events are one-cycle pulses on clk_sys.
// Notes: The release is sticky until reset or upstream disconnect.
module hub_link_pm_gate (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // Control
   input wire logic lp_disable,
   input wire logic force_accept_seen,
   input wire logic upstream_disconnect,
   // Requests
   input wire logic lp_initiate_req,
   input wire logic lp_accept_req,
   output logic lp_initiate_ok,
   output logic lp_accept_ok
);

   logic released_ff;
   wire logic nxt_released;

   // A disconnect ends the release; a force accept in that same cycle still wins
   assign nxt_released = force_accept_seen ? 1'b1 : (upstream_disconnect ? 1'b0 : released_ff);

   // Release stays until reset or upstream disconnect
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         released_ff <= 1'b0;
      end else if (clk_en) begin
         released_ff <= nxt_released;
      end
   end

   // Blocked while disabled, unless a force accept has been seen or is being seen
   wire logic lp_allowed;
   assign lp_allowed = !lp_disable || released_ff || force_accept_seen;
   assign lp_initiate_ok = lp_initiate_req && lp_allowed;
   assign lp_accept_ok = lp_accept_req && lp_allowed;

endmodule

/* File: hub_identity_and_device_config_regs.sv */
// Purpose: Byte-wide identity and device configuration registers of a four-port hub.
// Assumes: One byte write port shared by the EEPROM loader and the SMBus slave.
// Notes: Straps are caught in the first enabled cycle after reset release.
`include "hub_cfg_defs.svh"

// How it works
// - Vendor ID high byte is a writable byte with a default maker code.
// - SuperSpeed descriptor (product_id_ss) gets product ID low byte unchanged.
// - Legacy descriptor gets product ID low byte with bit 1 inverted.
// - Product ID high byte is writable with a default maker value.
// - Custom serial enable bit 6 gates EEPROM load or host writes of serial.
// - Low-power disable blocks U1/U2 both ways unless force accept occurs.
// - After force accept, U1/U2 normal until reset or upstream disconnect.
// - Bit 5 takes serial data strap at reset release.
// - Bit 4 takes indicator strap at reset release.
// - Bit 3 takes gang strap at reset release.
// - Bit 2 takes power management strap at reset release.
// - Power select 0: switching and over-current both supported.
// - Power select 1, bus powered: switching only, no over-current.
// - Power select 1, self powered: over-current only, no switching.
// - Timeout override turns nonzero downstream timeouts into FF; zero stays.
// - Bit 1 takes serial clock strap at reset release.
// - EEPROM reloads bits 5..1; SMBus host may overwrite them after straps.
// - Bit 0 reads zero and ignores writes.
// - Byte access; writes only accepted in EEPROM or SMBus mode.
// - EEPROM image loads only if first byte is 55h, else leave mode.
module hub_identity_and_device_config_regs #(
   parameter int PORTS = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // Strap pins
   input wire logic serial_data_strap_pin,
   input wire logic serial_clock_strap_pin,
   input wire logic indicator_strap_pin,
   input wire logic gang_strap_pin,
   input wire logic power_mgmt_strap_pin,
   // Mode selection
   input wire logic eeprom_mode,
   input wire logic smbus_mode,
   // Byte access port
   input wire logic byte_wr,
   input wire logic byte_rd,
   input wire logic [7:0] byte_addr,
   input wire logic [7:0] byte_wdata,
   output logic [7:0] byte_rdata,
   output logic byte_rvalid,
   // Loader status
   input wire logic eeprom_done,
   output logic eeprom_aborted,
   output logic cfg_mode_active,
   // Descriptor identity
   output logic [15:0] vendor_id,
   output logic [15:0] product_id_ss,
   output logic [15:0] product_id_hs,
   // Configuration outputs
   output logic custom_serial_enable,
   output logic serial_load_from_eeprom,
   output logic serial_host_writable,
   output logic port_indicator_select,
   output logic ganged_power,
   // Power management
   input wire logic self_powered,
   output logic power_switch_supported,
   output logic overcurrent_supported,
   // Link power management
   input wire logic force_accept_seen,
   input wire logic upstream_disconnect,
   input wire logic [PORTS:0] lp_initiate_req,
   input wire logic [PORTS:0] lp_accept_req,
   output logic [PORTS:0] lp_initiate_ok,
   output logic [PORTS:0] lp_accept_ok,
   // Downstream idle timeouts
   input wire logic [PORTS*8-1:0] sw_timeout,
   output logic [PORTS*8-1:0] eff_timeout
);

   // Registers
   hub_cfg_pkg::cfg_byte_t vendor_id_high_ff;
   hub_cfg_pkg::cfg_byte_t product_id_low_ff;
   hub_cfg_pkg::cfg_byte_t product_id_high_ff;
   hub_cfg_pkg::cfg_byte_t device_config_ff;
   hub_cfg_pkg::cfg_mode_e mode_ff;
   hub_cfg_pkg::load_state_e load_ff;
   logic straps_taken_ff;
   logic aborted_ff;
   hub_cfg_pkg::cfg_byte_t rdata_ff;
   logic rvalid_ff;

   hub_cfg_pkg::cfg_mode_e nxt_mode;
   hub_cfg_pkg::load_state_e nxt_load;
   hub_cfg_pkg::cfg_byte_t nxt_device_config;

   // Address decode
   wire logic hit_sig;
   wire logic hit_vid_h;
   wire logic hit_pid_l;
   wire logic hit_pid_h;
   wire logic hit_cfg;
   assign hit_sig = (byte_addr == `OFS_SIGNATURE);
   assign hit_vid_h = (byte_addr == `OFS_VENDOR_ID_HIGH);
   assign hit_pid_l = (byte_addr == `OFS_PRODUCT_ID_LOW);
   assign hit_pid_h = (byte_addr == `OFS_PRODUCT_ID_HIGH);
   assign hit_cfg = (byte_addr == `OFS_DEVICE_CONFIG);

   // Writes are only honoured in a configuration mode; EEPROM bytes must follow a good signature
   wire logic in_smbus;
   wire logic eeprom_copying;
   wire logic wr_ok;
   wire logic signature_good;
   assign in_smbus = (mode_ff == hub_cfg_pkg::MODE_SMBUS);
   assign eeprom_copying = (mode_ff == hub_cfg_pkg::MODE_EEPROM) && (load_ff == hub_cfg_pkg::LOAD_COPY);
   assign wr_ok = byte_wr && straps_taken_ff && (in_smbus || eeprom_copying);
   assign signature_good = (byte_wdata == `EEPROM_SIGNATURE);

   // A wrong first byte drops the loader back to defaults and leaves a sticky flag behind
   wire logic bad_signature;
   assign bad_signature = (load_ff == hub_cfg_pkg::LOAD_CHECK) && byte_wr && hit_sig && !signature_good;

   // Only an EEPROM copy ends on the done pulse; the host's completion flag lives outside this block,
   // so a stray done pulse in SMBus mode must not close host access
   wire logic copy_end;
   assign copy_end = eeprom_done && (mode_ff == hub_cfg_pkg::MODE_EEPROM);

   // Per-register write enables, kept out of the storage process so that it stays a plain list
   wire logic wr_vid_h;
   wire logic wr_pid_l;
   wire logic wr_pid_h;
   wire logic wr_cfg;
   assign wr_vid_h = wr_ok && hit_vid_h;
   assign wr_pid_l = wr_ok && hit_pid_l;
   assign wr_pid_h = wr_ok && hit_pid_h;
   assign wr_cfg = wr_ok && hit_cfg;

   // Loader: first EEPROM byte must carry the signature
   always_comb begin
      nxt_load = load_ff;
      nxt_mode = mode_ff;
      unique case (load_ff)
         hub_cfg_pkg::LOAD_IDLE: begin
            if (straps_taken_ff) begin
               if (eeprom_mode) begin
                  nxt_mode = hub_cfg_pkg::MODE_EEPROM;
                  nxt_load = hub_cfg_pkg::LOAD_CHECK;
               end else if (smbus_mode) begin
                  nxt_mode = hub_cfg_pkg::MODE_SMBUS;
                  nxt_load = hub_cfg_pkg::LOAD_COPY;
               end else begin
                  nxt_load = hub_cfg_pkg::LOAD_DONE;
               end
            end
         end
         hub_cfg_pkg::LOAD_CHECK: begin
            if (byte_wr && hit_sig) begin
               if (signature_good) begin
                  nxt_load = hub_cfg_pkg::LOAD_COPY;
               end else begin
                  nxt_mode = hub_cfg_pkg::MODE_DEFAULT;
                  nxt_load = hub_cfg_pkg::LOAD_DONE;
               end
            end
         end
         hub_cfg_pkg::LOAD_COPY: begin
            if (copy_end) begin
               nxt_mode = hub_cfg_pkg::MODE_DEFAULT;
               nxt_load = hub_cfg_pkg::LOAD_DONE;
            end
         end
         hub_cfg_pkg::LOAD_DONE: begin
            nxt_load = hub_cfg_pkg::LOAD_DONE;
         end
      endcase
   end

   // Straps feed bits 5..1 once; afterwards writes may replace bits 6..1
   always_comb begin
      nxt_device_config = device_config_ff;
      if (!straps_taken_ff) begin
         nxt_device_config[`BIT_LP_DISABLE] = serial_data_strap_pin;
         nxt_device_config[`BIT_PORT_IND] = indicator_strap_pin;
         nxt_device_config[`BIT_GANGED] = gang_strap_pin;
         nxt_device_config[`BIT_PWR_MGMT] = power_mgmt_strap_pin;
         nxt_device_config[`BIT_TIMEOUT_OVR] = serial_clock_strap_pin;
      end else if (wr_cfg) begin
         nxt_device_config = byte_wdata & `CFG_WRITE_MASK;
      end
   end

   // Mode and loader state
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mode_ff <= hub_cfg_pkg::MODE_DEFAULT;
         load_ff <= hub_cfg_pkg::LOAD_IDLE;
         straps_taken_ff <= 1'b0;
         aborted_ff <= 1'b0;
      end else if (clk_en) begin
         mode_ff <= nxt_mode;
         load_ff <= nxt_load;
         straps_taken_ff <= 1'b1;
         aborted_ff <= aborted_ff || bad_signature;
      end
   end

   // Register storage; defaults hold unless a configuration source writes, except config bits 5..1, which take the straps
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         vendor_id_high_ff <= `RST_VENDOR_ID_HIGH;
         product_id_low_ff <= `RST_PRODUCT_ID_LOW;
         product_id_high_ff <= `RST_PRODUCT_ID_HIGH;
         device_config_ff <= 8'h00;
      end else if (clk_en) begin
         if (wr_vid_h) begin
            vendor_id_high_ff <= byte_wdata;
         end
         if (wr_pid_l) begin
            product_id_low_ff <= byte_wdata;
         end
         if (wr_pid_h) begin
            product_id_high_ff <= byte_wdata;
         end
         device_config_ff <= nxt_device_config;
      end
   end

   // Read mux; unmapped bytes read zero
   // The signature byte is only checked in flight and never stored, so offset zero reads zero too
   wire hub_cfg_pkg::cfg_byte_t rd_mux;
   assign rd_mux = hit_vid_h ? vendor_id_high_ff :
                   hit_pid_l ? product_id_low_ff :
                   hit_pid_h ? product_id_high_ff :
                   hit_cfg ? device_config_ff : 8'h00;

   // Read data registered, valid the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
      end else if (clk_en) begin
         rvalid_ff <= byte_rd;
         if (byte_rd) begin
            rdata_ff <= rd_mux;
         end
      end
   end
   assign byte_rdata = rdata_ff;
   assign byte_rvalid = rvalid_ff;
   assign eeprom_aborted = aborted_ff;
   assign cfg_mode_active = (mode_ff != hub_cfg_pkg::MODE_DEFAULT);

   // Descriptor identity; low vendor byte lives elsewhere, tied to zero here
   assign vendor_id = {vendor_id_high_ff, 8'h00};
   assign product_id_ss = {product_id_high_ff, product_id_low_ff};
   assign product_id_hs = {product_id_high_ff, product_id_low_ff ^ `PID_LEGACY_TOGGLE};

   // Configuration decode
   assign custom_serial_enable = device_config_ff[`BIT_CUSTOM_SERIAL];
   assign serial_load_from_eeprom = custom_serial_enable && eeprom_copying;
   assign serial_host_writable = custom_serial_enable && in_smbus;
   assign port_indicator_select = device_config_ff[`BIT_PORT_IND];
   assign ganged_power = device_config_ff[`BIT_GANGED];

   // Power management support by power source
   wire logic pwr_sel;
   assign pwr_sel = device_config_ff[`BIT_PWR_MGMT];
   assign power_switch_supported = !pwr_sel || !self_powered;
   assign overcurrent_supported = !pwr_sel || self_powered;

   // One gate per port, upstream at index 0 and downstream ports above it
   // Every gate sees the same force accept and disconnect, so their releases move together
   genvar gi;
   generate
      for (gi = 0; gi <= PORTS; gi++) begin : g_pm
         hub_link_pm_gate u_pm_gate (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .clk_en(clk_en),
            .lp_disable(device_config_ff[`BIT_LP_DISABLE]),
            .force_accept_seen(force_accept_seen),
            .upstream_disconnect(upstream_disconnect),
            .lp_initiate_req(lp_initiate_req[gi]),
            .lp_accept_req(lp_accept_req[gi]),
            .lp_initiate_ok(lp_initiate_ok[gi]),
            .lp_accept_ok(lp_accept_ok[gi])
         );
      end
   endgenerate

   // Timeout override per downstream port; the upstream port has no downstream timeout
   generate
      for (gi = 0; gi < PORTS; gi++) begin : g_tmo
         hub_timeout_override u_tmo (
            .override_en(device_config_ff[`BIT_TIMEOUT_OVR]),
            .timeout_in(sw_timeout[gi*8 +: 8]),
            .timeout_out(eff_timeout[gi*8 +: 8])
         );
      end
   endgenerate

endmodule

/* File: cfg_chk.sv */
// Purpose: Port-level checks of the hub identity and configuration bank.
// Assumes: One clock domain; rst_n synchronous active low.
// Notes: Bound to the design top from the bench file.
module cfg_chk #(
   parameter int PORTS = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // Byte port
   input wire logic byte_rd,
   input wire logic byte_wr,
   input wire logic byte_rvalid,
   input wire logic [7:0] byte_addr,
   input wire logic [7:0] byte_rdata,
   // Identity and config outputs
   input wire logic [15:0] vendor_id,
   input wire logic [15:0] product_id_ss,
   input wire logic [15:0] product_id_hs,
   input wire logic custom_serial_enable,
   input wire logic serial_host_writable,
   input wire logic serial_load_from_eeprom,
   input wire logic self_powered,
   input wire logic power_switch_supported,
   input wire logic overcurrent_supported,
   // Link power and timeouts
   input wire logic force_accept_seen,
   input wire logic [PORTS:0] lp_initiate_req,
   input wire logic [PORTS:0] lp_accept_req,
   input wire logic [PORTS:0] lp_initiate_ok,
   input wire logic [PORTS:0] lp_accept_ok,
   input wire logic [PORTS*8-1:0] sw_timeout,
   input wire logic [PORTS*8-1:0] eff_timeout
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   chk_read_answer: assert property (byte_rd && clk_en |=> byte_rvalid)
      else $error("read strobe not answered next cycle");
   chk_rvalid_cause: assert property (byte_rvalid && $past(clk_en) |-> $past(byte_rd))
      else $error("read valid without a read strobe");
   chk_cfg_reserved: assert property (byte_rvalid && $past(byte_addr) == 8'h05 |-> !byte_rdata[7] && !byte_rdata[0])
      else $error("reserved config bit reads one");
   chk_pid_legacy: assert property (product_id_hs == (product_id_ss ^ 16'h0002))
      else $error("legacy product code not bit 1 toggled");
   chk_ocd_self: assert property (self_powered |-> overcurrent_supported)
      else $error("self powered hub without over-current detection");
   chk_switch_bus: assert property (!self_powered |-> power_switch_supported)
      else $error("bus powered hub without power switching");
   chk_timeout_map: assert property (eff_timeout[7:0] == sw_timeout[7:0]
      || (sw_timeout[7:0] != 8'h00 && eff_timeout[7:0] == 8'hFF))
      else $error("downstream timeout mapped wrongly");
   chk_lp_gate: assert property ((lp_initiate_ok & ~lp_initiate_req) == '0 && (lp_accept_ok & ~lp_accept_req) == '0)
      else $error("link power grant without request");
   chk_force_grant: assert property (force_accept_seen |-> lp_initiate_ok == lp_initiate_req
      && lp_accept_ok == lp_accept_req)
      else $error("force accept did not release link power");
   chk_serial_gate: assert property (serial_host_writable || serial_load_from_eeprom |-> custom_serial_enable)
      else $error("serial access without custom serial enable");
   chk_vid_hold: assert property (!byte_wr |=> $stable(vendor_id))
      else $error("vendor id changed without a write");
endmodule

/* File: cfg_src.sv */
// Purpose: Behavioural configuration source, SMBus host or EEPROM loader.
// Assumes: Drives on falling edges, one byte per strobe.
// Notes: Address and data are inverted when released so stale values never match.
module cfg_src (
   // Clock
   input wire logic clk_sys,
   // Byte port
   output logic byte_wr,
   output logic byte_rd,
   output logic eeprom_done,
   output logic [7:0] byte_addr,
   output logic [7:0] byte_wdata,
   input wire logic [7:0] byte_rdata,
   input wire logic byte_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      byte_wr = 1'b0;
      byte_rd = 1'b0;
      eeprom_done = 1'b0;
      byte_addr = 8'hA5;
      byte_wdata = 8'h5A;
   end

   // One byte write; images start with the signature byte at offset zero
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      byte_addr = a;
      byte_wdata = d;
      byte_wr = 1'b1;
      @(negedge clk_sys);
      byte_wr = 1'b0;
      byte_addr = ~a;
      byte_wdata = ~d;
   endtask

   // One byte read, answer taken the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge clk_sys);
      byte_addr = a;
      byte_rd = 1'b1;
      @(negedge clk_sys);
      byte_rd = 1'b0;
      byte_addr = ~a;
      v = byte_rvalid;
      d = byte_rdata;
   endtask

   // End of an EEPROM copy
   task automatic fin_copy();
      @(negedge clk_sys);
      eeprom_done = 1'b1;
      @(negedge clk_sys);
      eeprom_done = 1'b0;
   endtask
endmodule

/* File: tb.sv */
// Purpose: Self-checking bench for the hub identity and configuration bank.
// Assumes: clk_en high except for one frozen write; cfg_src plays the configuration source.
// Notes: Straps and mode are chosen at each reset.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PORTS = 4;
   logic clk_sys, rst_n, clk_en, serial_data_strap_pin, serial_clock_strap_pin, indicator_strap_pin;
   logic gang_strap_pin, power_mgmt_strap_pin, eeprom_mode, smbus_mode, byte_wr, byte_rd, eeprom_done;
   logic self_powered, force_accept_seen, upstream_disconnect, byte_rvalid, eeprom_aborted, cfg_mode_active;
   logic custom_serial_enable, serial_load_from_eeprom, serial_host_writable, port_indicator_select;
   logic ganged_power, power_switch_supported, overcurrent_supported, rv;
   logic [7:0] byte_addr, byte_wdata, byte_rdata, rdat;
   logic [15:0] vendor_id, product_id_ss, product_id_hs;
   logic [PORTS:0] lp_initiate_req, lp_accept_req, lp_initiate_ok, lp_accept_ok;
   logic [PORTS*8-1:0] sw_timeout, eff_timeout;
   int failures, checks;

   hub_identity_and_device_config_regs #(.PORTS(PORTS)) u_hub_identity_and_device_config_regs (.*);
   cfg_src u_cfg_src (.*);

   // Free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      u_cfg_src.rd(a, rdat, rv);
      chk("rvalid", 32'h0000_0001, 32'(rv));
      chk(nm, 32'(exp), 32'(rdat));
   endtask

   // Straps land in bits 5..1 in the order data, indicator, gang, power, clock
   task automatic do_reset(input logic [4:0] st, input logic e, input logic s);
      @(negedge clk_sys);
      rst_n = 1'b0;
      {serial_data_strap_pin, indicator_strap_pin, gang_strap_pin, power_mgmt_strap_pin, serial_clock_strap_pin} = st;
      eeprom_mode = e;
      smbus_mode = s;
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      {serial_data_strap_pin, indicator_strap_pin, gang_strap_pin, power_mgmt_strap_pin, serial_clock_strap_pin} = ~st;
   endtask

   task automatic t_straps();
      logic [4:0] pat [2] = '{5'b10101, 5'b01010};
      foreach (pat[i]) begin
         do_reset(pat[i], 1'b0, 1'b1);
         rdchk("cfg", 8'h05, {2'b00, pat[i], 1'b0});
         chk("ind", 32'(pat[i][3]), 32'(port_indicator_select));
         chk("gang", 32'(pat[i][2]), 32'(ganged_power));
      end
      rdchk("vid", 8'h02, 8'h12);
      rdchk("pidl", 8'h03, 8'h34);
      rdchk("pidh", 8'h04, 8'h56);
   endtask

   task automatic t_smbus();
      u_cfg_src.wr(8'h05, 8'hFF);
      chk("mode", 32'h0000_0001, 32'(cfg_mode_active));
      rdchk("cfg", 8'h05, 8'h7E);
      u_cfg_src.wr(8'h02, 8'hAB);
      u_cfg_src.wr(8'h03, 8'hC5);
      u_cfg_src.wr(8'h04, 8'h9A);
      chk("vid", 32'h0000_00AB, 32'(vendor_id[15:8]));
      @(negedge clk_sys);
      clk_en = 1'b0;
      u_cfg_src.wr(8'h02, 8'h11);
      clk_en = 1'b1;
      chk("vid_frozen", 32'h0000_00AB, 32'(vendor_id[15:8]));
      chk("pid_ss", 32'h0000_9AC5, 32'(product_id_ss));
      chk("pid_hs", 32'h0000_9AC7, 32'(product_id_hs));
      rdchk("unmapped", 8'hF0, 8'h00);
      u_cfg_src.wr(8'h05, 8'h40);
      chk("ser_host", 32'h0000_0001, 32'(serial_host_writable));
      chk("ser_load", 32'h0000_0000, 32'(serial_load_from_eeprom));
      u_cfg_src.wr(8'h05, 8'h00);
      chk("ser_en", 32'h0000_0000, 32'(custom_serial_enable));
   endtask

   task automatic t_power();
      for (int b = 0; b < 2; b++) begin
         u_cfg_src.wr(8'h05, b[0] ? 8'h04 : 8'h00);
         for (int s = 0; s < 2; s++) begin
            @(negedge clk_sys);
            self_powered = s[0];
            #1;
            chk("pwr_sw", 32'(!b[0] || !s[0]), 32'(power_switch_supported));
            chk("ocd", 32'(!b[0] || s[0]), 32'(overcurrent_supported));
         end
      end
   endtask

   task automatic t_timeout_lp();
      @(negedge clk_sys);
      sw_timeout = 32'hFF80_0100;
      u_cfg_src.wr(8'h05, 8'h22);
      chk("eff_ovr", 32'hFFFF_FF00, eff_timeout);
      lp_initiate_req = '1;
      lp_accept_req = '1;
      #1;
      chk("lp_off", 32'h0000_0000, 32'({lp_initiate_ok, lp_accept_ok}));
      @(negedge clk_sys);
      force_accept_seen = 1'b1;
      #1;
      chk("lp_force", 32'h0000_03FF, 32'({lp_initiate_ok, lp_accept_ok}));
      @(negedge clk_sys);
      force_accept_seen = 1'b0;
      #1;
      chk("lp_sticky", 32'h0000_03FF, 32'({lp_initiate_ok, lp_accept_ok}));
      @(negedge clk_sys);
      upstream_disconnect = 1'b1;
      @(negedge clk_sys);
      upstream_disconnect = 1'b0;
      #1;
      chk("lp_disc", 32'h0000_0000, 32'({lp_initiate_ok, lp_accept_ok}));
      u_cfg_src.wr(8'h05, 8'h00);
      chk("lp_on", 32'h0000_03FF, 32'({lp_initiate_ok, lp_accept_ok}));
      chk("eff_raw", 32'hFF80_0100, eff_timeout);
   endtask

   task automatic t_eeprom();
      do_reset(5'b00000, 1'b1, 1'b0);
      u_cfg_src.wr(8'h00, 8'h55);
      chk("mode", 32'h0000_0001, 32'(cfg_mode_active));
      u_cfg_src.wr(8'h05, 8'h7E);
      chk("ser_load", 32'h0000_0001, 32'(serial_load_from_eeprom));
      rdchk("cfg", 8'h05, 8'h7E);
      u_cfg_src.wr(8'h02, 8'h3C);
      u_cfg_src.fin_copy();
      chk("mode", 32'h0000_0000, 32'(cfg_mode_active));
      u_cfg_src.wr(8'h02, 8'hC3);
      rdchk("vid", 8'h02, 8'h3C);
      chk("abort", 32'h0000_0000, 32'(eeprom_aborted));
      do_reset(5'b11111, 1'b1, 1'b0);
      u_cfg_src.wr(8'h00, 8'hAA);
      u_cfg_src.wr(8'h02, 8'h77);
      rdchk("vid", 8'h02, 8'h12);
      rdchk("cfg", 8'h05, 8'h3E);
      chk("abort", 32'h0000_0001, 32'(eeprom_aborted));
      chk("mode", 32'h0000_0000, 32'(cfg_mode_active));
      do_reset(5'b00000, 1'b0, 1'b0);
      u_cfg_src.wr(8'h04, 8'h77);
      rdchk("pidh", 8'h04, 8'h56);
      chk("mode", 32'h0000_0000, 32'(cfg_mode_active));
   endtask

   task automatic finish_test();
      if (failures == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Main sequence; straps and mode get values at the first reset, the other inputs at time zero
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      self_powered = 1'b0;
      force_accept_seen = 1'b0;
      upstream_disconnect = 1'b0;
      lp_initiate_req = '0;
      lp_accept_req = '0;
      sw_timeout = '0;
      t_straps();
      t_smbus();
      t_power();
      t_timeout_lp();
      t_eeprom();
      finish_test();
   end

   // Watchdog, far beyond the some 120 cycles the run needs
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      finish_test();
   end
endmodule

bind hub_identity_and_device_config_regs cfg_chk #(.PORTS(PORTS)) u_cfg_chk (.*);
